// File: sss_bus_master.sv
// Purpose: behavioural bus master for the two-wire link of the slave
// Assumes: pull-up on sda; the system clock only paces the bit timing
// Notes:   scl stands high between frames; low phase stretched where slave drives
`default_nettype none
module sss_bus_master (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // the slave turns sda late after a clock fall, so those low phases are stretched
  task automatic put(input logic b, input logic slow, output logic s);
    tick(slow ? 6 : 2);
    sda_low_o <= !b;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    s = sda_i;
    scl_o <= 1'b0;
  endtask
  task automatic start();
    tick(6);
    sda_low_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_low_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    tick(6);
    sda_low_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    sda_low_o <= 1'b0;
    tick(4);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put(d[i], i == 7, s);
    put(1'b1, 1'b1, s);
    ack = !s;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put(1'b1, 1'b1, s);
      d[i] = s;
    end
    put(last, 1'b1, s);
  endtask
endmodule // sss_bus_master
`default_nettype wire

// File: sss_defines.vh
// Purpose: shared constants of the supervisor serial command slave
// Assumes: included by bare name from every design file that needs it
// Notes:   definitions only, guarded against double inclusion
`ifndef SSS_DEFINES_VH
`define SSS_DEFINES_VH

// slave address layout: bits 7..4 fixed, bit 3 fixed, bit 2 strap, bit 1 ignored
`define SSS_ADDR_FIXED      4'hA
`define SSS_ADDR_BIT3       1'b0

// command and pointer codes
`define SSS_CMD_BLK_WR      8'hC0
`define SSS_CMD_BLK_RD      8'hC1
`define SSS_CMD_REBOOT      8'hC4
`define SSS_REG_LAST        8'h2F
`define SSS_USER_FIRST      8'h40
`define SSS_CFG_LAST        8'h9F
`define SSS_REG_DATA_LIMIT  8'h50
`define SSS_EE_PRESET_FIRST 8'h80
`define SSS_EE_PRESET_LAST  8'h82
`define SSS_BLK_MAX         8'h10
`define SSS_BLK_RD_COUNT    8'h10

// timing
`define SSS_BOOT_TIME_NS    2500000
`define SSS_CLK_PERIOD_NS   40
`define SSS_BOOT_CYCLES     (`SSS_BOOT_TIME_NS / `SSS_CLK_PERIOD_NS)

// reset values and buffer shape
`define SSS_PIN_IDLE        1'b1
`define SSS_PTR_RESET       8'h00
`define SSS_FIFO_DEPTH      8
`define SSS_FIFO_AW         3
`define SSS_FIFO_WIDTH      16

`endif

// File: sss_fifo.v
// Purpose: write buffer between the serial slave and the register/eeprom port
// Assumes: single clock, synchronous active-high reset
// Notes:   output stage is a register so the consumer sees flop outputs
`default_nettype none
`include "sss_defines.vh"

module sss_fifo #(
  parameter WIDTH = `SSS_FIFO_WIDTH,
  parameter DEPTH = `SSS_FIFO_DEPTH,
  parameter AW    = `SSS_FIFO_AW
) (
  input  wire             clk_sys_i,
  input  wire             sys_rst_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output reg              out_valid_o,
  input  wire             out_ready_i,
  output reg  [WIDTH-1:0] out_data_o
);

  localparam [AW:0]   FULL_CNT = DEPTH[AW:0];
  localparam [AW-1:0] LAST_IDX = DEPTH[AW-1:0] - 1'b1;

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_idx;
  reg  [AW-1:0]    rd_idx;
  reg  [AW:0]      count;
  wire             push;
  wire             pop;

  assign in_ready_o = (count != FULL_CNT);
  assign push       = in_valid_i & in_ready_o;
  // refill the output stage whenever it is empty or being taken
  assign pop        = (count != {(AW+1){1'b0}}) & (~out_valid_o | out_ready_i);

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_idx] <= in_data_i;
    end
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      wr_idx      <= {AW{1'b0}};
      rd_idx      <= {AW{1'b0}};
      count       <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_idx <= (wr_idx == LAST_IDX) ? {AW{1'b0}} : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx     <= (rd_idx == LAST_IDX) ? {AW{1'b0}} : rd_idx + 1'b1;
        out_data_o <= mem[rd_idx];
      end
      if (pop) begin
        out_valid_o <= 1'b1;
      end else if (out_ready_i) begin
        out_valid_o <= 1'b0;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // sss_fifo

`default_nettype wire

// File: sss_slave.v
// Purpose: two-wire command slave of a configurable power-supply supervisor
// Assumes: scl/sda/strap come from pins; ee_busy_i and rd_data_i are on clk_sys_i
// Notes:   scl is oversampled, never used as a clock; rd_data_i must follow
//          rd_addr_o combinationally
//
// Behaviour
// - a STOP aborts a transfer anywhere, except within the START's own SCL high phase
// - back-to-back writes are accepted after repeated START or STOP plus START
// - slave drives SDA low through the 9th clock to acknowledge received bytes
// - when transmitting, slave releases SDA in the 9th clock and samples master ack
// - command byte is NACKed during reboot, EEPROM write, or for illegal address
// - address bits 7..4 are 1010, bit 3 zero, bit 2 strap, bit 1 ignored
// - address bit 0 selects direction, zero write, one read
// - single send byte loads the pointer; NACK when disallowed or busy
// - command C0h is acknowledged and opens a block write
// - command C1h announces a block read via repeated START
// - single send byte C4h starts a software reboot
// - register write command must be 00h to 2Fh; data stored only if valid
// - write-byte command NACKed when invalid or an internal operation runs
// - block write is C0h, count 1 to 16, then that many acked data bytes
// - block pointer stops at 2Fh or 9Fh; excess bytes rewrite 9Fh and are dropped at 2Fh
// - location 2Fh is read-only and keeps its content on any write
// - read byte is command, repeated START, read address, one byte, NACK, STOP
// - receive byte returns data at the current pointer, which advances after each data byte read and holds at 2Fh or 9Fh
// - command below 50h takes data; 80h-82h data presets EEPROM address low byte
// - user EEPROM 40h-7Fh, config EEPROM 80h-9Fh; increment passes 7Fh to 80h
// - block read returns count 16 then data; master may stop early
// - every access is NACKed until the boot download ends, at most 2.5ms
`default_nettype none
`include "sss_defines.vh"

module sss_slave #(
  parameter BOOT_CYCLES = `SSS_BOOT_CYCLES,
  parameter BOOT_CW     = 17
) (
  input  wire        clk_sys_i,
  input  wire        sys_rst_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe_o,
  input  wire        addr_select_strap_i,
  input  wire        ee_busy_i,
  output reg  [7:0]  rd_addr_o,
  input  wire [7:0]  rd_data_i,
  output reg         rd_strobe_o,
  output wire        wr_valid_o,
  input  wire        wr_ready_i,
  output wire [7:0]  wr_addr_o,
  output wire [7:0]  wr_data_o,
  output reg         reboot_o,
  output reg         boot_busy_o
);

  localparam [5:0] ST_IDLE  = 6'h01;
  localparam [5:0] ST_RX    = 6'h02;
  localparam [5:0] ST_ACK   = 6'h04;
  localparam [5:0] ST_TX    = 6'h08;
  localparam [5:0] ST_TXACK = 6'h10;
  localparam [5:0] ST_WAIT  = 6'h20;

  localparam [2:0] K_ADDR = 3'h0;
  localparam [2:0] K_CMD  = 3'h1;
  localparam [2:0] K_DATA = 3'h2;
  localparam [2:0] K_CNT  = 3'h3;
  localparam [2:0] K_BLK  = 3'h4;
  localparam [2:0] K_NONE = 3'h5;

  localparam [BOOT_CW-1:0] BOOT_LOAD = BOOT_CYCLES[BOOT_CW-1:0] - 1'b1;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three flops, a change is taken once stages 2 and 3 agree
  wire [2:0] pin_raw;
  wire [2:0] pin_flt;

  assign pin_raw = {addr_select_strap_i, sda_i, scl_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      reg m1;
      reg m2;
      reg m3;
      reg flt;
      always @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
          m1  <= `SSS_PIN_IDLE;
          m2  <= `SSS_PIN_IDLE;
          m3  <= `SSS_PIN_IDLE;
          flt <= `SSS_PIN_IDLE;
        end else begin
          m1 <= pin_raw[gi];
          m2 <= m1;
          m3 <= m2;
          if (m2 == m3) begin
            flt <= m3;
          end
        end
      end
      assign pin_flt[gi] = flt;
    end
  endgenerate

  wire scl_f   = pin_flt[0];
  wire sda_f   = pin_flt[1];
  wire strap_f = pin_flt[2];

  reg  scl_q;
  reg  sda_q;

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      scl_q <= `SSS_PIN_IDLE;
      sda_q <= `SSS_PIN_IDLE;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  wire scl_rise  = scl_f & ~scl_q;
  wire scl_fall  = ~scl_f & scl_q;
  wire start_det = scl_f & scl_q & sda_q & ~sda_f;
  wire stop_det  = scl_f & scl_q & ~sda_q & sda_f;

  //////////////////////////////////////////////////////////////////////////////
  // boot download timer: runs after reset and after each reboot
  reg [BOOT_CW-1:0] boot_cnt;

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      boot_cnt    <= BOOT_LOAD;
      boot_busy_o <= 1'b1;
    end else begin
      if (reboot_o) begin
        boot_cnt <= BOOT_LOAD;
      end else if (boot_cnt != {BOOT_CW{1'b0}}) begin
        boot_cnt <= boot_cnt - 1'b1;
      end
      boot_busy_o <= reboot_o | (boot_cnt != {BOOT_CW{1'b0}});
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  function legal_ptr;
    input [7:0] b;
    begin
      legal_ptr = (b <= `SSS_REG_LAST) ||
                  ((b >= `SSS_USER_FIRST) && (b <= `SSS_CFG_LAST));
    end
  endfunction

  // saturating increment; 7Fh rolls into 80h naturally
  function [7:0] sat_inc;
    input [7:0] p;
    begin
      sat_inc = ((p == `SSS_REG_LAST) || (p == `SSS_CFG_LAST)) ? p : p + 8'h01;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  reg  [5:0]  state;
  reg  [2:0]  kind;
  reg  [3:0]  bit_cnt;
  reg  [7:0]  shreg;
  reg  [7:0]  cmd;
  reg  [4:0]  blk_left;
  reg         ack_ok;
  reg         rw_read;
  reg         blk_rd_pend;
  reg         tx_data;
  reg         start_hi;
  reg         reboot_arm;
  reg         push_valid;
  reg  [15:0] push_data;
  wire        fifo_ready;

  wire [7:0] tx_next  = blk_rd_pend ? `SSS_BLK_RD_COUNT : rd_data_i;
  wire       addr_hit = (shreg[7:4] == `SSS_ADDR_FIXED) && (shreg[3] == `SSS_ADDR_BIT3) &&
                        (shreg[2] == strap_f) && ~boot_busy_o;
  wire       cmd_busy = boot_busy_o | ee_busy_i;
  wire       cmd_code = (shreg == `SSS_CMD_BLK_WR) || (shreg == `SSS_CMD_BLK_RD) ||
                        (shreg == `SSS_CMD_REBOOT);
  wire       cmd_ok   = ~cmd_busy & (legal_ptr(shreg) | cmd_code);
  wire       cnt_ok   = (shreg != 8'h00) && (shreg <= `SSS_BLK_MAX);
  wire       preset   = (cmd >= `SSS_EE_PRESET_FIRST) && (cmd <= `SSS_EE_PRESET_LAST);

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state       <= ST_IDLE;
      kind        <= K_ADDR;
      bit_cnt     <= 4'h0;
      shreg       <= 8'h00;
      cmd         <= 8'h00;
      blk_left    <= 5'h00;
      ack_ok      <= 1'b0;
      rw_read     <= 1'b0;
      blk_rd_pend <= 1'b0;
      tx_data     <= 1'b0;
      start_hi    <= 1'b0;
      reboot_arm  <= 1'b0;
      push_valid  <= 1'b0;
      push_data   <= 16'h0000;
      rd_addr_o   <= `SSS_PTR_RESET;
      rd_strobe_o <= 1'b0;
      reboot_o    <= 1'b0;
      sda_o       <= 1'b0;
      sda_oe_o    <= 1'b0;
    end else begin
      push_valid  <= 1'b0;
      rd_strobe_o <= 1'b0;
      reboot_o    <= 1'b0;
      sda_o       <= 1'b0;
      if (scl_fall) begin
        start_hi <= 1'b0;
      end
      if (start_det) begin
        // a repeated start keeps the pointer and a pending block read
        state      <= ST_RX;
        kind       <= K_ADDR;
        bit_cnt    <= 4'h0;
        sda_oe_o   <= 1'b0;
        start_hi   <= 1'b1;
        reboot_arm <= 1'b0;
      end else if (stop_det && !start_hi) begin
        state       <= ST_IDLE;
        sda_oe_o    <= 1'b0;
        blk_rd_pend <= 1'b0;
        reboot_arm  <= 1'b0;
        reboot_o    <= reboot_arm;
      end else begin
        case (state)
          ST_RX: begin
            if (scl_rise && bit_cnt != 4'h8) begin
              shreg   <= {shreg[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              state <= ST_ACK;
              case (kind)
                K_ADDR: begin
                  rw_read  <= shreg[0];
                  ack_ok   <= addr_hit;
                  sda_oe_o <= addr_hit;
                end
                K_CMD: begin
                  ack_ok   <= cmd_ok;
                  sda_oe_o <= cmd_ok;
                  if (cmd_ok) begin
                    cmd         <= shreg;
                    blk_rd_pend <= (shreg == `SSS_CMD_BLK_RD);
                    reboot_arm  <= (shreg == `SSS_CMD_REBOOT);
                    if (legal_ptr(shreg)) begin
                      rd_addr_o <= shreg;
                    end
                  end
                end
                K_DATA: begin
                  ack_ok     <= fifo_ready;
                  sda_oe_o   <= fifo_ready;
                  reboot_arm <= 1'b0;
                  if (fifo_ready) begin
                    if (preset) begin
                      rd_addr_o <= shreg;
                    end else if (cmd < `SSS_REG_DATA_LIMIT || legal_ptr(cmd)) begin
                      push_valid <= (cmd != `SSS_REG_LAST);
                      push_data  <= {cmd, shreg};
                    end
                  end
                end
                K_CNT: begin
                  ack_ok   <= cnt_ok;
                  sda_oe_o <= cnt_ok;
                  blk_left <= shreg[4:0];
                end
                K_BLK: begin
                  ack_ok   <= fifo_ready && (blk_left != 5'h00);
                  sda_oe_o <= fifo_ready && (blk_left != 5'h00);
                  if (fifo_ready && (blk_left != 5'h00)) begin
                    push_valid <= (rd_addr_o != `SSS_REG_LAST);
                    push_data  <= {rd_addr_o, shreg};
                    rd_addr_o  <= sat_inc(rd_addr_o);
                    blk_left   <= blk_left - 5'h01;
                  end
                end
                default: begin
                  ack_ok   <= 1'b0;
                  sda_oe_o <= 1'b0;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_oe_o <= 1'b0;
              bit_cnt  <= 4'h0;
              if (!ack_ok) begin
                state <= ST_WAIT;
              end else if (kind == K_ADDR && rw_read) begin
                // first byte of a read goes out on this same falling edge
                shreg       <= tx_next;
                sda_oe_o    <= ~tx_next[7];
                tx_data     <= ~blk_rd_pend;
                rd_strobe_o <= ~blk_rd_pend;
                blk_rd_pend <= 1'b0;
                bit_cnt     <= 4'h1;
                state       <= ST_TX;
              end else begin
                state <= ST_RX;
                case (kind)
                  K_ADDR: begin
                    kind <= K_CMD;
                  end
                  K_CMD: begin
                    if (cmd == `SSS_CMD_BLK_WR) begin
                      kind <= K_CNT;
                    end else if (cmd == `SSS_CMD_BLK_RD || cmd == `SSS_CMD_REBOOT) begin
                      kind <= K_NONE;
                    end else begin
                      kind <= K_DATA;
                    end
                  end
                  K_CNT: begin
                    kind <= K_BLK;
                  end
                  K_BLK: begin
                    kind <= K_BLK;
                  end
                  default: begin
                    kind <= K_NONE;
                  end
                endcase
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h8) begin
                sda_oe_o <= 1'b0;
                state    <= ST_TXACK;
              end else begin
                shreg    <= {shreg[6:0], 1'b0};
                sda_oe_o <= ~shreg[6];
                bit_cnt  <= bit_cnt + 4'h1;
              end
            end
          end
          ST_TXACK: begin
            if (scl_rise) begin
              ack_ok <= ~sda_f;
              if (tx_data) begin
                rd_addr_o <= sat_inc(rd_addr_o);
              end
            end else if (scl_fall) begin
              if (ack_ok) begin
                shreg       <= tx_next;
                sda_oe_o    <= ~tx_next[7];
                tx_data     <= ~blk_rd_pend;
                rd_strobe_o <= ~blk_rd_pend;
                blk_rd_pend <= 1'b0;
                bit_cnt     <= 4'h1;
                state       <= ST_TX;
              end else begin
                state <= ST_WAIT;
              end
            end
          end
          ST_WAIT: begin
            sda_oe_o <= 1'b0;
          end
          ST_IDLE: begin
            sda_oe_o <= 1'b0;
          end
          default: begin
            state    <= ST_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // a full buffer makes data bytes NACK, since scl cannot be stretched here
  wire [15:0] fifo_out;

  sss_fifo #(
    .WIDTH (`SSS_FIFO_WIDTH),
    .DEPTH (`SSS_FIFO_DEPTH),
    .AW    (`SSS_FIFO_AW)
  ) u_wbuf (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (fifo_ready),
    .in_data_i   (push_data),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (fifo_out)
  );

  assign wr_addr_o = fifo_out[15:8];
  assign wr_data_o = fifo_out[7:0];

endmodule // sss_slave

`default_nettype wire

// File: sss_slave_chk.sv
// Purpose: concurrent checks on the serial command slave ports
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound from the bench top; watches design inputs and outputs
`default_nettype none
module sss_slave_chk #(
  parameter int BOOT_CYCLES = 62500
) (
  input wire logic       clk_sys_i,
  input wire logic       sys_rst_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       addr_select_strap_i,
  input wire logic       ee_busy_i,
  input wire logic [7:0] rd_addr_o,
  input wire logic [7:0] rd_data_i,
  input wire logic       rd_strobe_o,
  input wire logic       wr_valid_o,
  input wire logic       wr_ready_i,
  input wire logic [7:0] wr_addr_o,
  input wire logic [7:0] wr_data_o,
  input wire logic       reboot_o,
  input wire logic       boot_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int busy_cnt;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////
  // length of the current boot window; a counter keeps the check cheap
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || !boot_busy_o) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  sequence s_reboot;
    reboot_o ##1 (boot_busy_o && !reboot_o);
  endsequence
  a_sda_only_low: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  a_boot_nack: assert property (boot_busy_o |-> !sda_oe_o)
    else $error("slave answers during boot");
  a_boot_len: assert property ($fell(boot_busy_o) |-> busy_cnt >= BOOT_CYCLES - 2
    && busy_cnt <= BOOT_CYCLES + 2) else $error("boot window length wrong");
  a_reboot_busy: assert property (reboot_o |-> s_reboot)
    else $error("reboot pulse not followed by boot");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line turned while clock high");
  a_strobe_once: assert property (rd_strobe_o |=> !rd_strobe_o)
    else $error("read strobe longer than one cycle");
  a_wr_stable: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o
    && $stable(wr_addr_o) && $stable(wr_data_o)) else $error("write word changed");
  a_wr_range: assert property (wr_valid_o |-> wr_addr_o < 8'h2F
    || wr_addr_o inside {[8'h40:8'h9F]}) else $error("write to illegal place");
endmodule // sss_slave_chk
`default_nettype wire

// File: tb.sv
// Purpose: self-checking bench for the serial command slave
// Assumes: behavioural master on the link, pull-up on sda, short boot window
// Notes:   far-side memory answers each address with address xor 5A
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BOOT = 200;
  logic       clk_sys_i, sys_rst_i, addr_select_strap, ee_busy, wr_ready;
  logic       scl, m_low, sda_w, sda_o, sda_oe, rd_strobe, wr_valid, reboot, boot_busy;
  logic [7:0] rd_addr, rd_data, wr_addr, wr_data;
  int         fail_count = 0;
  int         checks = 0;
  int         strobes = 0;
  // open drain: whoever pulls low wins over the pull-up
  assign sda_w   = (sda_oe ? sda_o : 1'b1) & !m_low;
  assign rd_data = rd_addr ^ 8'h5A;
  always @(posedge clk_sys_i) begin
    if (rd_strobe === 1'b1) strobes++;
  end
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = !clk_sys_i;
  end
  sss_slave #(.BOOT_CYCLES(BOOT)) u_sss_slave (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_select_strap_i(addr_select_strap),
    .ee_busy_i(ee_busy), .rd_addr_o(rd_addr), .rd_data_i(rd_data), .rd_strobe_o(rd_strobe),
    .wr_valid_o(wr_valid), .wr_ready_i(wr_ready), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
    .reboot_o(reboot), .boot_busy_o(boot_busy));
  sss_bus_master u_sss_bus_master (
    .clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(m_low));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic st();
    u_sss_bus_master.start();
  endtask
  task automatic sp();
    u_sss_bus_master.stop();
  endtask
  task automatic snd(input logic [7:0] b, input logic e);
    logic a;
    u_sss_bus_master.send(b, a);
    check({7'h00, a}, {7'h00, e});
  endtask
  task automatic rcv(input logic last, input logic [7:0] e);
    logic [7:0] d;
    u_sss_bus_master.recv(last, d);
    check(d, e);
  endtask
  task automatic take_wr(input logic [7:0] a, input logic [7:0] d);
    int n = 0;
    while (wr_valid !== 1'b1 && n < 100) begin
      @(posedge clk_sys_i);
      n++;
    end
    check({7'h00, wr_valid}, 8'h01);
    check(wr_addr, a);
    check(wr_data, d);
    wr_ready <= 1'b1;
    @(posedge clk_sys_i);
    wr_ready <= 1'b0;
  endtask
  task automatic wait_boot();
    repeat (BOOT + 20) @(posedge clk_sys_i);
    check({7'h00, boot_busy}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_boot();
    st();
    snd(8'hA4, 1'b0);
    sp();
    wait_boot();
    $display("t_boot done");
  endtask
  task automatic t_addr();
    logic [7:0] ad [4];
    logic       ex [4];
    ad = '{8'hA0, 8'hAC, 8'hB4, 8'hA6};
    ex = '{1'b0, 1'b0, 1'b0, 1'b1};
    foreach (ad[i]) begin
      st();
      snd(ad[i], ex[i]);
      sp();
    end
    addr_select_strap <= 1'b0;
    st();
    snd(8'hA0, 1'b1);
    sp();
    addr_select_strap <= 1'b1;
    $display("t_addr done");
  endtask
  task automatic t_write();
    logic s;
    st();
    snd(8'hA4, 1'b1);
    repeat (3) u_sss_bus_master.put(1'b1, 1'b1, s);
    sp();
    st();
    snd(8'hA4, 1'b1);
    snd(8'h05, 1'b1);
    snd(8'h3C, 1'b1);
    sp();
    take_wr(8'h05, 8'h3C);
    st();
    snd(8'hA4, 1'b1);
    snd(8'h30, 1'b0);
    sp();
    ee_busy <= 1'b1;
    st();
    snd(8'hA4, 1'b1);
    snd(8'h05, 1'b0);
    sp();
    ee_busy <= 1'b0;
    $display("t_write done");
  endtask
  task automatic t_block();
    st();
    snd(8'hA4, 1'b1);
    snd(8'h2E, 1'b1);
    st();
    snd(8'hA4, 1'b1);
    snd(8'hC0, 1'b1);
    snd(8'h03, 1'b1);
    snd(8'h11, 1'b1);
    snd(8'h22, 1'b1);
    snd(8'h33, 1'b1);
    sp();
    check(rd_addr, 8'h2F);
    take_wr(8'h2E, 8'h11);
    repeat (20) @(posedge clk_sys_i);
    check({7'h00, wr_valid}, 8'h00);
    st();
    snd(8'hA4, 1'b1);
    snd(8'hC0, 1'b1);
    snd(8'h11, 1'b0);
    sp();
    $display("t_block done");
  endtask
  task automatic t_read();
    int s0 = strobes;
    st();
    snd(8'hA4, 1'b1);
    snd(8'h10, 1'b1);
    st();
    snd(8'hA5, 1'b1);
    rcv(1'b0, 8'h10 ^ 8'h5A);
    rcv(1'b1, 8'h11 ^ 8'h5A);
    sp();
    st();
    snd(8'hA5, 1'b1);
    rcv(1'b1, 8'h12 ^ 8'h5A);
    sp();
    st();
    snd(8'hA4, 1'b1);
    snd(8'hC1, 1'b1);
    st();
    snd(8'hA5, 1'b1);
    rcv(1'b0, 8'h10);
    rcv(1'b1, 8'h13 ^ 8'h5A);
    sp();
    st();
    snd(8'hA4, 1'b1);
    snd(8'h81, 1'b1);
    snd(8'h7F, 1'b1);
    st();
    snd(8'hA5, 1'b1);
    rcv(1'b0, 8'h7F ^ 8'h5A);
    rcv(1'b1, 8'h80 ^ 8'h5A);
    sp();
    check({7'h00, wr_valid}, 8'h00);
    check(8'(strobes - s0), 8'h06);
    $display("t_read done");
  endtask
  task automatic t_reboot();
    st();
    snd(8'hA4, 1'b1);
    snd(8'hC4, 1'b1);
    sp();
    repeat (10) @(posedge clk_sys_i);
    check({7'h00, boot_busy}, 8'h01);
    st();
    snd(8'hA4, 1'b0);
    sp();
    wait_boot();
    $display("t_reboot done");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    sys_rst_i = 1'b1;
    addr_select_strap = 1'b1;
    ee_busy = 1'b0;
    wr_ready = 1'b0;
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    t_boot();
    t_addr();
    t_write();
    t_block();
    t_read();
    t_reboot();
    summarize();
  end
  // several times the expected run of roughly five thousand clocks
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    fail_count++;
    summarize();
  end
endmodule // tb
bind sss_slave sss_slave_chk #(.BOOT_CYCLES(BOOT_CYCLES)) u_sss_slave_chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_select_strap_i(addr_select_strap_i),
  .ee_busy_i(ee_busy_i), .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i),
  .rd_strobe_o(rd_strobe_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
  .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .reboot_o(reboot_o),
  .boot_busy_o(boot_busy_o));
`default_nettype wire
